/* File: core/ioe_exec.v */
// Executor for port, converter and system control instructions
// Overview of operation
// - Port groups zero and one load into accumulator and drive from it.
// - Input from groups two or three fills accumulator bits one and zero.
// - Output to groups two or three drives accumulator bits one and zero.
// - Set-all sets drive port; bit set and clear use index 0 to 5.
// - Drive port bit test skips when indexed bit is zero.
// - Separate instructions set and clear the single port.
// - Single port test skips when the port holds one.
// - Second single port reads into and writes from accumulator bit 0.
// - Three key wakeup registers are writable and readable.
// - Three pull-up registers are write-only.
// - Conversion mode result read gives bits 9-6 to B, 5-2 to A.
// - Comparator mode result read gives bits 7-4 to B, 3-0 to A.
// - Low result read puts result bits 1,0 into accumulator bits 3,2.
// - Comparator write is no-op in conversion mode, loads from B and A otherwise.
// - Converter control readable and writable; bit 3 selects comparator mode.
// - Start clears done flag then starts conversion or comparator operation.
// - Done test skips and clears flag when enable bit zero; else no-op.
// - No-op only advances the program counter.
// - Back-up entry takes effect only directly after the arm instruction.
// - Power flag test skips when flag is one, leaving flag unchanged.
// - Watchdog test skips and clears flag; after stop arm also stops watchdog.
// - Oscillator select instructions and clock control transfers.
`timescale 1ns/10ps
`include "ioe_consts.vh"
module ioe_exec (
    input  wire        mclk_in,
    input  wire        rst_b_in,
    input  wire        instr_valid_in,
    input  wire [9:0]  instr_code_in,
    input  wire [3:0]  acc_in,
    input  wire [3:0]  acc_b_in,
    input  wire [2:0]  index_in,
    input  wire [3:0]  port_group_zero_in,
    input  wire [3:0]  port_group_one_in,
    input  wire [1:0]  port_group_two_in,
    input  wire [1:0]  port_group_three_in,
    input  wire [5:0]  drive_port_in,
    input  wire        single_port_in,
    input  wire        second_single_port_in,
    input  wire [9:0]  conv_result_in,
    input  wire        conv_done_set_in,
    input  wire        conversion_irq_enable_bit_in,
    input  wire        backup_return_flag_in,
    input  wire        watchdog_flag_one_set_in,
    output reg  [3:0]  acc_out,
    output reg         acc_we_out,
    output reg  [3:0]  acc_b_out,
    output reg         acc_b_we_out,
    output reg         skip_out,
    output reg         pc_inc_out,
    output reg  [3:0]  port_group_zero_out,
    output reg  [3:0]  port_group_one_out,
    output reg  [1:0]  port_group_two_out,
    output reg  [1:0]  port_group_three_out,
    output reg  [5:0]  drive_port_out,
    output reg         single_port_out,
    output reg         second_single_port_out,
    output reg  [11:0] key_wakeup_ctrl_out,
    output reg  [11:0] pullup_ctrl_out,
    output reg  [7:0]  comparator_reg_out,
    output reg  [3:0]  converter_ctrl_out,
    output reg         conv_start_out,
    output reg         comparator_start_out,
    output reg         conversion_done_flag_out,
    output reg         backup_enter_out,
    output reg         watchdog_flag_one_out,
    output reg         watchdog_stop_out,
    output reg         osc_ceramic_out,
    output reg         osc_rc_out,
    output reg  [3:0]  clock_ctrl_out
);
    wire [3:0] pg0_s;
    wire [3:0] pg1_s;
    wire [1:0] pg2_s;
    wire [1:0] pg3_s;
    wire [5:0] drv_s;
    wire       cp_s;
    wire       kp_s;

    // Pins are asynchronous to mclk_in, so every one goes through the synchroniser
    ioe_pin_sync #(.W(20)) u_sync (
        .mclk_in  (mclk_in),
        .rst_b_in (rst_b_in),
        .d_in     ({port_group_zero_in, port_group_one_in, port_group_two_in,
                    port_group_three_in, drive_port_in, single_port_in,
                    second_single_port_in}),
        .q_out    ({pg0_s, pg1_s, pg2_s, pg3_s, drv_s, cp_s, kp_s})
    );

    reg        bkp_armed_r;
    reg        wd_armed_r;
    reg [3:0]  acc_nxt;
    reg        acc_we_nxt;
    reg [3:0]  accb_nxt;
    reg        accb_we_nxt;
    reg        skip_nxt;
    reg [5:0]  drv_nxt;
    reg        cmode;
    reg        idx_ok;

    function [3:0] kw_nib;
        input [11:0] v;
        input [1:0]  n;
        begin
            kw_nib = v[n*4 +: 4];
        end
    endfunction

    always @* begin
        acc_nxt     = `IOE_RST_NIBBLE;
        acc_we_nxt  = 1'b0;
        accb_nxt    = `IOE_RST_NIBBLE;
        accb_we_nxt = 1'b0;
        skip_nxt    = 1'b0;
        drv_nxt     = drive_port_out;
        cmode       = converter_ctrl_out[`IOE_MODE_BIT];
        idx_ok      = (index_in <= `IOE_DRV_MAX_IDX);
        if (instr_valid_in) begin
            case (instr_code_in)
                `IOE_OP_IN0: begin
                    acc_nxt = pg0_s;
                    acc_we_nxt = 1'b1;
                end
                `IOE_OP_IN1: begin
                    acc_nxt = pg1_s;
                    acc_we_nxt = 1'b1;
                end
                `IOE_OP_IN2: begin
                    acc_nxt = {2'b00, pg2_s};
                    acc_we_nxt = 1'b1;
                end
                `IOE_OP_IN3: begin
                    acc_nxt = {2'b00, pg3_s};
                    acc_we_nxt = 1'b1;
                end
                `IOE_OP_DRV_ALL: drv_nxt = `IOE_RST_DRV;
                `IOE_OP_DRV_CLR: begin
                    if (idx_ok) begin
                        drv_nxt[index_in] = 1'b0;
                    end
                end
                `IOE_OP_DRV_SET: begin
                    if (idx_ok) begin
                        drv_nxt[index_in] = 1'b1;
                    end
                end
                `IOE_OP_DRV_TEST: skip_nxt = idx_ok & ~drv_s[index_in];
                `IOE_OP_C_TEST: skip_nxt = cp_s;
                `IOE_OP_K_READ: begin
                    acc_nxt = {3'b000, kp_s};
                    acc_we_nxt = 1'b1;
                end
                `IOE_OP_KW0_RD: begin
                    acc_nxt = kw_nib(key_wakeup_ctrl_out, 2'd0);
                    acc_we_nxt = 1'b1;
                end
                `IOE_OP_KW1_RD: begin
                    acc_nxt = kw_nib(key_wakeup_ctrl_out, 2'd1);
                    acc_we_nxt = 1'b1;
                end
                `IOE_OP_KW2_RD: begin
                    acc_nxt = kw_nib(key_wakeup_ctrl_out, 2'd2);
                    acc_we_nxt = 1'b1;
                end
                `IOE_OP_RES_RD: begin
                    acc_we_nxt = 1'b1;
                    accb_we_nxt = 1'b1;
                    if (cmode) begin
                        accb_nxt = comparator_reg_out[7:4];
                        acc_nxt = comparator_reg_out[3:0];
                    end else begin
                        accb_nxt = conv_result_in[9:6];
                        acc_nxt = conv_result_in[5:2];
                    end
                end
                `IOE_OP_RES_LO_RD: begin
                    acc_nxt = {conv_result_in[1:0], 2'b00};
                    acc_we_nxt = 1'b1;
                end
                `IOE_OP_CNV_RD: begin
                    acc_nxt = converter_ctrl_out;
                    acc_we_nxt = 1'b1;
                end
                `IOE_OP_CNV_TEST: begin
                    skip_nxt = ~conversion_irq_enable_bit_in & conversion_done_flag_out;
                end
                `IOE_OP_PWR_TEST: skip_nxt = backup_return_flag_in;
                `IOE_OP_WD_TEST: skip_nxt = watchdog_flag_one_out;
                `IOE_OP_CLK_RD: begin
                    acc_nxt = clock_ctrl_out;
                    acc_we_nxt = 1'b1;
                end
                default: acc_nxt = `IOE_RST_NIBBLE;
            endcase
        end
    end

    wire is_op = instr_valid_in;
    wire op_cmp_wr = is_op & (instr_code_in == `IOE_OP_CMP_WR);
    wire op_start = is_op & (instr_code_in == `IOE_OP_CNV_START);
    wire op_ctest = is_op & (instr_code_in == `IOE_OP_CNV_TEST);
    wire op_wtest = is_op & (instr_code_in == `IOE_OP_WD_TEST);

    always @(posedge mclk_in) begin
        if (!rst_b_in) begin
            acc_out                  <= `IOE_RST_NIBBLE;
            acc_we_out               <= 1'b0;
            acc_b_out                <= `IOE_RST_NIBBLE;
            acc_b_we_out             <= 1'b0;
            skip_out                 <= 1'b0;
            pc_inc_out               <= 1'b0;
            port_group_zero_out      <= `IOE_RST_NIBBLE;
            port_group_one_out       <= `IOE_RST_NIBBLE;
            port_group_two_out       <= 2'b00;
            port_group_three_out     <= 2'b00;
            drive_port_out           <= `IOE_RST_DRV;
            single_port_out          <= 1'b0;
            second_single_port_out   <= 1'b0;
            key_wakeup_ctrl_out      <= 12'h000;
            pullup_ctrl_out          <= 12'h000;
            comparator_reg_out       <= 8'h00;
            converter_ctrl_out       <= `IOE_RST_NIBBLE;
            conv_start_out           <= 1'b0;
            comparator_start_out     <= 1'b0;
            conversion_done_flag_out <= 1'b0;
            backup_enter_out         <= 1'b0;
            watchdog_flag_one_out    <= 1'b0;
            watchdog_stop_out        <= 1'b0;
            osc_ceramic_out          <= 1'b0;
            osc_rc_out               <= 1'b0;
            clock_ctrl_out           <= `IOE_RST_NIBBLE;
            bkp_armed_r              <= 1'b0;
            wd_armed_r               <= 1'b0;
        end else begin
            acc_out        <= acc_nxt;
            acc_we_out     <= acc_we_nxt;
            acc_b_out      <= accb_nxt;
            acc_b_we_out   <= accb_we_nxt;
            skip_out       <= skip_nxt;
            pc_inc_out     <= is_op;
            drive_port_out <= drv_nxt;
            conv_start_out <= op_start & ~converter_ctrl_out[`IOE_MODE_BIT];
            comparator_start_out <= op_start & converter_ctrl_out[`IOE_MODE_BIT];
            backup_enter_out <= 1'b0;
            if (is_op) begin
                // Arms hold only across the very next instruction
                bkp_armed_r <= (instr_code_in == `IOE_OP_BKP_ARM);
                wd_armed_r  <= (instr_code_in == `IOE_OP_WD_ARM);
                case (instr_code_in)
                    `IOE_OP_OUT0: port_group_zero_out <= acc_in;
                    `IOE_OP_OUT1: port_group_one_out <= acc_in;
                    `IOE_OP_OUT2: port_group_two_out <= acc_in[1:0];
                    `IOE_OP_OUT3: port_group_three_out <= acc_in[1:0];
                    `IOE_OP_C_SET: single_port_out <= 1'b1;
                    `IOE_OP_C_CLR: single_port_out <= 1'b0;
                    `IOE_OP_K_WRITE: second_single_port_out <= acc_in[0];
                    `IOE_OP_KW0_WR: key_wakeup_ctrl_out[3:0] <= acc_in;
                    `IOE_OP_KW1_WR: key_wakeup_ctrl_out[7:4] <= acc_in;
                    `IOE_OP_KW2_WR: key_wakeup_ctrl_out[11:8] <= acc_in;
                    `IOE_OP_PU0_WR: pullup_ctrl_out[3:0] <= acc_in;
                    `IOE_OP_PU1_WR: pullup_ctrl_out[7:4] <= acc_in;
                    `IOE_OP_PU2_WR: pullup_ctrl_out[11:8] <= acc_in;
                    `IOE_OP_CNV_WR: converter_ctrl_out <= acc_in;
                    `IOE_OP_BKP_ENTER: backup_enter_out <= bkp_armed_r;
                    `IOE_OP_OSC_CER: osc_ceramic_out <= 1'b1;
                    `IOE_OP_OSC_RC: osc_ceramic_out <= 1'b0;
                    `IOE_OP_CLK_WR: clock_ctrl_out <= acc_in;
                    default: clock_ctrl_out <= clock_ctrl_out;
                endcase
                if (instr_code_in == `IOE_OP_OSC_CER || instr_code_in == `IOE_OP_OSC_RC) begin
                    osc_rc_out <= (instr_code_in == `IOE_OP_OSC_RC);
                end
            end
            if (op_cmp_wr && converter_ctrl_out[`IOE_MODE_BIT]) begin
                comparator_reg_out <= {acc_b_in, acc_in};
            end
            // Hardware set wins over an instruction clear in the same cycle
            if (conv_done_set_in) begin
                conversion_done_flag_out <= 1'b1;
            end else if (op_start) begin
                conversion_done_flag_out <= 1'b0;
            end else if (op_ctest && !conversion_irq_enable_bit_in) begin
                conversion_done_flag_out <= 1'b0;
            end
            if (watchdog_flag_one_set_in) begin
                watchdog_flag_one_out <= 1'b1;
            end else if (op_wtest) begin
                watchdog_flag_one_out <= 1'b0;
            end
            if (op_wtest && wd_armed_r) begin
                watchdog_stop_out <= 1'b1;
            end
        end
    end
endmodule

/* File: core/ioe_consts.vh */
// Constants for the port, converter and system instruction executor
`ifndef IOE_CONSTS_VH
`define IOE_CONSTS_VH
`define IOE_OP_NOP        10'h000
`define IOE_OP_BKP_ENTER  10'h008
`define IOE_OP_PWR_TEST   10'h003
`define IOE_OP_BKP_ARM    10'h05b
`define IOE_OP_DRV_ALL    10'h011
`define IOE_OP_DRV_CLR    10'h014
`define IOE_OP_DRV_SET    10'h015
`define IOE_OP_DRV_TEST   10'h024
`define IOE_OP_IN0        10'h260
`define IOE_OP_IN1        10'h261
`define IOE_OP_IN2        10'h262
`define IOE_OP_IN3        10'h263
`define IOE_OP_OUT0       10'h220
`define IOE_OP_OUT1       10'h221
`define IOE_OP_OUT2       10'h222
`define IOE_OP_OUT3       10'h223
`define IOE_OP_C_SET      10'h28d
`define IOE_OP_C_CLR      10'h28c
`define IOE_OP_C_TEST     10'h289
`define IOE_OP_K_READ     10'h26f
`define IOE_OP_K_WRITE    10'h21f
`define IOE_OP_KW0_WR     10'h21b
`define IOE_OP_KW0_RD     10'h256
`define IOE_OP_KW1_WR     10'h214
`define IOE_OP_KW1_RD     10'h259
`define IOE_OP_KW2_WR     10'h215
`define IOE_OP_KW2_RD     10'h25a
`define IOE_OP_PU0_WR     10'h22d
`define IOE_OP_PU1_WR     10'h22e
`define IOE_OP_PU2_WR     10'h22f
`define IOE_OP_RES_RD     10'h279
`define IOE_OP_RES_LO_RD  10'h249
`define IOE_OP_CMP_WR     10'h239
`define IOE_OP_CNV_RD     10'h244
`define IOE_OP_CNV_WR     10'h204
`define IOE_OP_CNV_START  10'h29f
`define IOE_OP_CNV_TEST   10'h287
`define IOE_OP_WD_ARM     10'h29c
`define IOE_OP_WD_TEST    10'h2a0
`define IOE_OP_OSC_CER    10'h29a
`define IOE_OP_OSC_RC     10'h29b
`define IOE_OP_CLK_RD     10'h252
`define IOE_OP_CLK_WR     10'h216
`define IOE_MODE_BIT      3
`define IOE_IRQEN_BIT     2
`define IOE_DRV_BITS      6
`define IOE_DRV_MAX_IDX   3'h5
`define IOE_RST_NIBBLE    4'h0
`define IOE_RST_DRV       6'h3f
`define IOE_SYNC_STAGES   3
`endif

/* File: core/ioe_pin_sync.v */
// Three-stage pin synchroniser; output changes once stages two and three agree
`timescale 1ns/10ps
module ioe_pin_sync #(
    parameter W = 1
) (
    input  wire         mclk_in,
    input  wire         rst_b_in,
    input  wire [W-1:0] d_in,
    output reg  [W-1:0] q_out
);
    reg [W-1:0] s1_r;
    reg [W-1:0] s2_r;
    reg [W-1:0] s3_r;
    integer i;
    always @(posedge mclk_in) begin
        if (!rst_b_in) begin
            s1_r  <= {W{1'b0}};
            s2_r  <= {W{1'b0}};
            s3_r  <= {W{1'b0}};
            q_out <= {W{1'b0}};
        end else begin
            s1_r <= d_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            for (i = 0; i < W; i = i + 1) begin
                if (s2_r[i] == s3_r[i]) begin
                    q_out[i] <= s3_r[i];
                end
            end
        end
    end
endmodule

/* File: verif/ioe_exec_checker.sv */
// Concurrent checks on the instruction executor ports
`timescale 1ns/10ps
`include "ioe_consts.vh"
module ioe_exec_checker (
    input wire        mclk_in,
    input wire        rst_b_in,
    input wire        instr_valid_in,
    input wire [9:0]  instr_code_in,
    input wire [3:0]  acc_in,
    input wire [3:0]  acc_b_in,
    input wire [9:0]  conv_result_in,
    input wire        conv_done_set_in,
    input wire        conversion_irq_enable_bit_in,
    input wire        backup_return_flag_in,
    input wire [3:0]  acc_out,
    input wire [3:0]  acc_b_out,
    input wire        skip_out,
    input wire        pc_inc_out,
    input wire [3:0]  port_group_zero_out,
    input wire [5:0]  drive_port_out,
    input wire        single_port_out,
    input wire [7:0]  comparator_reg_out,
    input wire [3:0]  converter_ctrl_out,
    input wire        conv_start_out,
    input wire        comparator_start_out,
    input wire        conversion_done_flag_out,
    input wire        backup_enter_out
);
    reg  [9:0] res_q;
    reg  [7:0] ab_q;
    reg        mode_q;
    reg        arm_q;
    wire       v  = instr_valid_in;
    wire [9:0] op = instr_code_in;
    // Arm memory follows valid instructions only, gaps do not break it
    always @(posedge mclk_in) begin
        res_q  <= conv_result_in;
        ab_q   <= {acc_b_in, acc_in};
        mode_q <= converter_ctrl_out[3];
        if (!rst_b_in)
            arm_q <= 1'b0;
        else if (v)
            arm_q <= (op == `IOE_OP_BKP_ARM);
    end
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_b_in);
    a_out0_drives_acc: assert property (v && op == `IOE_OP_OUT0 |=>
        port_group_zero_out == ab_q[3:0]) else $error("port zero output wrong");
    a_drv_all_ones: assert property (v && op == `IOE_OP_DRV_ALL |=>
        drive_port_out == 6'h3f) else $error("drive port not all ones");
    a_single_set_clr: assert property (v && (op == `IOE_OP_C_SET || op == `IOE_OP_C_CLR) |=>
        single_port_out == $past(instr_code_in[0])) else $error("single port level wrong");
    a_conv_result_read: assert property (v && op == `IOE_OP_RES_RD && !converter_ctrl_out[3] |=>
        acc_b_out == res_q[9:6] && acc_out == res_q[5:2]) else $error("result read wrong");
    a_low_result_read: assert property (v && op == `IOE_OP_RES_LO_RD |=>
        acc_out == {res_q[1:0], 2'b00}) else $error("low result read wrong");
    a_cmp_write_mode: assert property (v && op == `IOE_OP_CMP_WR |=>
        comparator_reg_out == (mode_q ? ab_q : $past(comparator_reg_out)))
        else $error("comparator write wrong");
    a_start_kind: assert property (v && op == `IOE_OP_CNV_START |=>
        conv_start_out == !mode_q && comparator_start_out == mode_q) else $error("start wrong");
    a_start_clears: assert property (v && op == `IOE_OP_CNV_START && !conv_done_set_in |=>
        !conversion_done_flag_out) else $error("done flag not cleared");
    a_done_test_skip: assert property (v && op == `IOE_OP_CNV_TEST &&
        conversion_done_flag_out |=> skip_out == !$past(conversion_irq_enable_bit_in))
        else $error("done test skip wrong");
    a_pc_advance: assert property (v |=> pc_inc_out ##1 !pc_inc_out || $past(instr_valid_in))
        else $error("pc increment wrong");
    a_backup_after_arm: assert property ((v && op == `IOE_OP_BKP_ARM) ##1
        (v && op == `IOE_OP_BKP_ENTER) |=> backup_enter_out) else $error("backup not entered");
    a_backup_needs_arm: assert property (v && op == `IOE_OP_BKP_ENTER && !arm_q |=>
        !backup_enter_out) else $error("backup entered without arm");
    a_power_test_skip: assert property (v && op == `IOE_OP_PWR_TEST |=>
        skip_out == $past(backup_return_flag_in)) else $error("power test skip wrong");
    c_backup: cover property (backup_enter_out);
    c_skip: cover property (skip_out);
    c_cmp_start: cover property (comparator_start_out);
endmodule
bind ioe_exec ioe_exec_checker i_ioe_exec_checker (.mclk_in, .rst_b_in, .instr_valid_in,
    .instr_code_in, .acc_in, .acc_b_in, .conv_result_in, .conv_done_set_in,
    .conversion_irq_enable_bit_in, .backup_return_flag_in, .acc_out, .acc_b_out, .skip_out,
    .pc_inc_out, .port_group_zero_out, .drive_port_out, .single_port_out, .comparator_reg_out,
    .converter_ctrl_out, .conv_start_out, .comparator_start_out, .conversion_done_flag_out,
    .backup_enter_out);

/* File: verif/test_io_adc_system_instr_exec.sv */
// Self-checking bench for the port, converter and system instruction executor
`timescale 1ns/10ps
`include "ioe_consts.vh"
module test_io_adc_system_instr_exec;
    logic mclk_in = 0, rst_b_in = 0, instr_valid_in = 0, single_port_in = 0;
    logic second_single_port_in = 1, conv_done_set_in = 0, conversion_irq_enable_bit_in = 0;
    logic backup_return_flag_in = 0, watchdog_flag_one_set_in = 0;
    logic [9:0] instr_code_in = 10'h000, conv_result_in = 10'h2d7;
    logic [3:0] acc_in = 4'h0, acc_b_in = 4'h0, port_group_zero_in = 4'ha, port_group_one_in = 4'h5;
    logic [2:0] index_in = 3'h0;
    logic [1:0] port_group_two_in = 2'h2, port_group_three_in = 2'h1;
    logic [5:0] drive_port_in = 6'h2a;
    logic [3:0] acc_out, acc_b_out, port_group_zero_out, port_group_one_out, converter_ctrl_out;
    logic [3:0] clock_ctrl_out;
    logic [1:0] port_group_two_out, port_group_three_out;
    logic [5:0] drive_port_out;
    logic [11:0] key_wakeup_ctrl_out, pullup_ctrl_out;
    logic [7:0] comparator_reg_out;
    logic acc_we_out, acc_b_we_out, skip_out, pc_inc_out, single_port_out, second_single_port_out;
    logic conv_start_out, comparator_start_out, conversion_done_flag_out, backup_enter_out;
    logic watchdog_flag_one_out, watchdog_stop_out, osc_ceramic_out, osc_rc_out;
    int n_errors = 0, checks_done = 0;
    ioe_exec i_ioe_exec (.mclk_in, .rst_b_in, .instr_valid_in, .instr_code_in, .acc_in, .acc_b_in,
        .index_in, .port_group_zero_in, .port_group_one_in, .port_group_two_in,
        .port_group_three_in, .drive_port_in, .single_port_in, .second_single_port_in,
        .conv_result_in, .conv_done_set_in, .conversion_irq_enable_bit_in,
        .backup_return_flag_in, .watchdog_flag_one_set_in, .acc_out, .acc_we_out, .acc_b_out,
        .acc_b_we_out, .skip_out, .pc_inc_out, .port_group_zero_out, .port_group_one_out,
        .port_group_two_out, .port_group_three_out, .drive_port_out, .single_port_out,
        .second_single_port_out, .key_wakeup_ctrl_out, .pullup_ctrl_out, .comparator_reg_out,
        .converter_ctrl_out, .conv_start_out, .comparator_start_out, .conversion_done_flag_out,
        .backup_enter_out, .watchdog_flag_one_out, .watchdog_stop_out, .osc_ceramic_out,
        .osc_rc_out, .clock_ctrl_out);
    always #4 mclk_in = ~mclk_in;
    task automatic chk(input string n, input logic [11:0] s, input logic [11:0] e);
        checks_done++;
        if (s !== e) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    // Second code follows with no gap
    task automatic run2(input logic [9:0] c, input logic [9:0] c2);
        @(posedge mclk_in);
        instr_valid_in <= 1'b1;
        instr_code_in <= c;
        @(posedge mclk_in);
        instr_code_in <= c2;
        @(posedge mclk_in);
        instr_valid_in <= 1'b0;
        #1;
    endtask
    task automatic run(input logic [9:0] c, input logic [3:0] a = 0, input logic [3:0] b = 0,
                       input logic [2:0] y = 0);
        @(posedge mclk_in);
        instr_valid_in <= 1'b1;
        instr_code_in <= c;
        acc_in <= a;
        acc_b_in <= b;
        index_in <= y;
        @(posedge mclk_in);
        instr_valid_in <= 1'b0;
        #1;
    endtask
    // Pins need time to pass the synchroniser
    task automatic settle;
        repeat (5) @(posedge mclk_in);
    endtask
    task automatic t_ports;
        settle;
        run(`IOE_OP_IN0); chk("in0", acc_out, 4'ha); chk("we", acc_we_out, 1);
        run(`IOE_OP_IN1); chk("in1", acc_out, 4'h5);
        run(`IOE_OP_IN2); chk("in2", acc_out, 4'h2);
        run(`IOE_OP_IN3); chk("in3", acc_out, 4'h1);
        run(`IOE_OP_OUT0, 4'h6); chk("out0", port_group_zero_out, 4'h6);
        run(`IOE_OP_OUT1, 4'h9); chk("out1", port_group_one_out, 4'h9);
        run(`IOE_OP_OUT2, 4'hd); chk("out2", port_group_two_out, 2'h1);
        run(`IOE_OP_OUT3, 4'he); chk("out3", port_group_three_out, 2'h2);
        run(`IOE_OP_K_READ); chk("kin", acc_out, 4'h1);
        run(`IOE_OP_K_WRITE, 4'he); chk("kout", second_single_port_out, 0);
        run(`IOE_OP_K_WRITE, 4'h1); chk("kout", second_single_port_out, 1);
        @(posedge mclk_in);
        #1;
        chk("we_pulse", acc_we_out, 0);
        $display("ports test done");
    endtask
    task automatic t_drive;
        for (int i = 0; i < 6; i++) begin
            run(`IOE_OP_DRV_CLR, 0, 0, i[2:0]);
            chk("drv_clr", drive_port_out, {6'h3f << i + 1});
        end
        run(`IOE_OP_DRV_SET, 0, 0, 3'h6); chk("drv_y6", drive_port_out, 0);
        run(`IOE_OP_DRV_SET, 0, 0, 3'h5); chk("drv_set", drive_port_out, 6'h20);
        run(`IOE_OP_DRV_ALL); chk("drv_all", drive_port_out, 6'h3f);
        run(`IOE_OP_DRV_TEST, 0, 0, 3'h0); chk("drv_t0", skip_out, 1);
        run(`IOE_OP_DRV_TEST, 0, 0, 3'h1); chk("drv_t1", skip_out, 0);
        run(`IOE_OP_C_SET); chk("c_set", single_port_out, 1);
        run(`IOE_OP_C_CLR); chk("c_clr", single_port_out, 0);
        @(posedge mclk_in);
        single_port_in <= 1'b1;
        settle;
        run(`IOE_OP_C_TEST); chk("c_t1", skip_out, 1);
        @(posedge mclk_in);
        single_port_in <= 1'b0;
        settle;
        run(`IOE_OP_C_TEST); chk("c_t0", skip_out, 0);
        $display("drive test done");
    endtask
    task automatic t_regs;
        run(`IOE_OP_KW0_WR, 4'h3); run(`IOE_OP_KW1_WR, 4'h5); run(`IOE_OP_KW2_WR, 4'hc);
        chk("kw", key_wakeup_ctrl_out, 12'hc53);
        run(`IOE_OP_KW0_RD); chk("kw0", acc_out, 4'h3);
        run(`IOE_OP_KW1_RD); chk("kw1", acc_out, 4'h5);
        run(`IOE_OP_KW2_RD); chk("kw2", acc_out, 4'hc);
        run(`IOE_OP_PU0_WR, 4'h1); run(`IOE_OP_PU1_WR, 4'h2); run(`IOE_OP_PU2_WR, 4'h4);
        chk("pu", pullup_ctrl_out, 12'h421);
        run(`IOE_OP_CLK_WR, 4'h7); run(`IOE_OP_CLK_RD); chk("clk", acc_out, 4'h7);
        run(`IOE_OP_CNV_WR, 4'h5); run(`IOE_OP_CNV_RD); chk("q", acc_out, 4'h5);
        $display("register test done");
    endtask
    task automatic t_conv;
        run(`IOE_OP_RES_RD); chk("rb", acc_b_out, 4'hb); chk("ra", acc_out, 4'h5);
        chk("bwe", acc_b_we_out, 1);
        run(`IOE_OP_RES_LO_RD); chk("rlo", acc_out, 4'hc);
        run(`IOE_OP_CMP_WR, 4'hc, 4'h3); chk("cmp0", comparator_reg_out, 0);
        run(`IOE_OP_CNV_START); chk("cst", conv_start_out, 1); chk("pst", comparator_start_out, 0);
        @(posedge mclk_in);
        conv_done_set_in <= 1'b1;
        conversion_irq_enable_bit_in <= 1'b1;
        @(posedge mclk_in);
        conv_done_set_in <= 1'b0;
        run(`IOE_OP_CNV_TEST); chk("adt1", skip_out, 0); chk("adf", conversion_done_flag_out, 1);
        @(posedge mclk_in);
        conversion_irq_enable_bit_in <= 1'b0;
        run(`IOE_OP_CNV_TEST); chk("adt0", skip_out, 1); chk("adf", conversion_done_flag_out, 0);
        run(`IOE_OP_CNV_WR, 4'h8);
        run(`IOE_OP_CMP_WR, 4'hc, 4'h3); chk("cmp1", comparator_reg_out, 8'h3c);
        run(`IOE_OP_RES_RD); chk("cb", acc_b_out, 4'h3); chk("ca", acc_out, 4'hc);
        run(`IOE_OP_CNV_START); chk("pst", comparator_start_out, 1); chk("cst", conv_start_out, 0);
        $display("converter test done");
    endtask
    task automatic t_sys;
        run(`IOE_OP_NOP); chk("pc", pc_inc_out, 1); chk("nwe", acc_we_out, 0);
        run(`IOE_OP_BKP_ENTER); chk("bk0", backup_enter_out, 0);
        run2(`IOE_OP_BKP_ARM, `IOE_OP_BKP_ENTER); chk("bk1", backup_enter_out, 1);
        @(posedge mclk_in);
        backup_return_flag_in <= 1'b1;
        watchdog_flag_one_set_in <= 1'b1;
        @(posedge mclk_in);
        watchdog_flag_one_set_in <= 1'b0;
        run(`IOE_OP_PWR_TEST); chk("p1", skip_out, 1);
        run(`IOE_OP_PWR_TEST); chk("p1", skip_out, 1);
        run(`IOE_OP_WD_TEST); chk("wsk", skip_out, 1); chk("wdf", watchdog_flag_one_out, 0);
        chk("wst0", watchdog_stop_out, 0);
        run2(`IOE_OP_WD_ARM, `IOE_OP_WD_TEST); chk("wst1", watchdog_stop_out, 1);
        run(`IOE_OP_OSC_CER); chk("cer", {osc_ceramic_out, osc_rc_out}, 2'h2);
        run(`IOE_OP_OSC_RC); chk("rc", {osc_ceramic_out, osc_rc_out}, 2'h1);
        $display("system test done");
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (4000) @(posedge mclk_in);
        n_errors++;
        tally_and_finish;
    end
    initial begin
        repeat (5) @(posedge mclk_in);
        rst_b_in <= 1'b1;
        @(posedge mclk_in);
        #1;
        chk("drv_rst", drive_port_out, 6'h3f);
        t_ports;
        t_drive;
        t_regs;
        t_conv;
        t_sys;
        tally_and_finish;
    end
endmodule
